// ==== hw/snd_pkg.sv ====
/* snd_pkg: opcodes, timing, status fields and carrier types of the
   serial NAND command sequencer. Assumes a 250 MHz core clock. */
package snd_pkg;
    localparam int CLK_NS = 4;
    localparam int T_RST_NS = 2000;
    localparam int T_RD_NS = 4000;
    localparam int T_RCBSY_NS = 1000;
    localparam int T_ECC_NS = 1000;

    localparam logic [7:0] OP_RESET = 8'hFF;
    localparam logic [7:0] OP_GETF = 8'h0F;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PREAD = 8'h13;
    localparam logic [7:0] OP_RAND = 8'h30;
    localparam logic [7:0] OP_LAST = 8'h3F;
    localparam logic [7:0] OP_RD1A = 8'h03;
    localparam logic [7:0] OP_RD1B = 8'h0B;
    localparam logic [7:0] OP_RD2 = 8'h3B;
    localparam logic [7:0] OP_RD4 = 8'h6B;
    localparam logic [7:0] OP_RDD = 8'hBB;
    localparam logic [7:0] OP_RDQ = 8'hEB;
    localparam logic [7:0] OP_ID = 8'h9F;

    localparam logic [7:0] FA_LOCK = 8'hA0;
    localparam logic [7:0] FA_CFG = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    localparam int ST_OIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_ECC = 4;
    localparam int ST_CACHE_READ_BUSY_FLAG = 7;
    localparam int PLANE_BIT = 6;

    localparam logic [4:0] LEN_ROW = 5'h18;
    localparam logic [4:0] LEN_COL = 5'h10;
    localparam logic [4:0] LEN_BYTE = 5'h08;
    localparam logic [4:0] LEN_QDMY = 5'h10;
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;

    typedef enum logic [2:0] {PH_OPC, PH_ADR, PH_DMY, PH_DAT, PH_IGN} snd_ph_t;
    typedef enum logic [1:0] {SRC_CACHE, SRC_ID, SRC_FEAT} snd_src_t;
    typedef enum logic [1:0] {AR_LOAD_CACHE, AR_LOAD_DATA, AR_TO_CACHE} snd_arr_op_t;
    typedef struct packed {
        logic        valid;
        snd_arr_op_t op;
        logic [16:0] row;
    } snd_arr_req_t;

    function automatic int cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : cyc
endpackage : snd_pkg

// ==== hw/snd_seq.sv ====
/* snd_seq: command sequencer of a serial NAND device: pin shifter, opcode
   decode, busy timers, status, identifier and cache readout.
   Assumes the cache answers cache_data_i one cycle after cache_col_o and
   the array acts on each arr_o request; serial clock far below clk_i. */
module snd_seq #(
    parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h5A  // arbitrary value
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // serial pins
    input  wire logic             cs_n_i,
    input  wire logic             sck_i,
    input  wire logic [3:0]       io_i,
    output logic [3:0]            io_o,
    output logic [3:0]            io_oe_o,
    // cache and array
    output logic [11:0]           cache_col_o,
    input  wire logic [7:0]       cache_data_i,
    output snd_pkg::snd_arr_req_t arr_o,
    output logic                  plane_o,
    input  wire logic [1:0]       ecc_stat_i,
    input  wire logic             ecc_en_i,
    // configuration and lock
    input  wire logic             cfg_wr_i,
    input  wire logic [2:0]       cfg_i,
    input  wire logic             lock_wr_i,
    input  wire logic [7:0]       lock_i,
    // status
    output logic                  write_enable_latch_o,
    output logic                  operation_in_progress_flag_o,
    output logic                  cache_read_busy_flag_o,
    output logic [1:0]            ecc_stat_o,
    output logic [2:0]            cfg_sel_o,
    output logic [7:0]            lock_o
);
    localparam logic [11:0] RST_C = 12'(snd_pkg::cyc(snd_pkg::T_RST_NS));
    localparam logic [11:0] RD_C = 12'(snd_pkg::cyc(snd_pkg::T_RD_NS));
    localparam logic [11:0] RC_C = 12'(snd_pkg::cyc(snd_pkg::T_RCBSY_NS));
    localparam logic [11:0] ECC_C = 12'(snd_pkg::cyc(snd_pkg::T_ECC_NS));
    localparam int RCN = snd_pkg::cyc(snd_pkg::T_RCBSY_NS);

    logic [5:0]            s1;
    logic [5:0]            s2;
    logic                  sck_q;
    logic                  cs_s;
    logic                  rise;
    logic                  fall;
    logic [3:0]            io_s;
    snd_pkg::snd_ph_t      ph;
    snd_pkg::snd_ph_t      d_ph;
    snd_pkg::snd_src_t     src;
    snd_pkg::snd_src_t     d_src;
    logic [7:0]            opc;
    logic [7:0]            opb;
    logic [7:0]            feat;
    logic [23:0]           sh;
    logic [23:0]           next_sh;
    logic [4:0]            cnt;
    logic [4:0]            next_cnt;
    logic [4:0]            len;
    logic [4:0]            d_len;
    logic [2:0]            w_in;
    logic [2:0]            w_out;
    logic [2:0]            d_w;
    logic [2:0]            d_wo;
    logic [2:0]            bcnt;
    logic [7:0]            sr;
    logic [7:0]            top;
    logic [7:0]            stat;
    logic [7:0]            src_byte;
    logic [3:0]            dv;
    logic [3:0]            oe_map;
    logic                  idx;
    logic                  operation_in_progress_flag;
    logic                  cache_read_busy_flag;
    logic                  idle;
    logic                  pend;
    logic [11:0]           otmr;
    logic [11:0]           ctmr;
    logic [11:0]           rc;
    logic [16:0]           rrow;
    logic                  op_done;
    logic                  adr_done;
    logic                  dmy_done;
    logic                  do_reset;
    logic                  do_wren;
    logic                  do_wrdi;
    logic                  do_page;
    logic                  do_rand;
    logic                  do_last;
    snd_pkg::snd_arr_req_t next_req;

    // pins cross into clk_i through two flops
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1 <= 6'h20;
            s2 <= 6'h20;
            sck_q <= 1'b0;
        end
        else
        begin
            s1 <= {cs_n_i, sck_i, io_i};
            s2 <= s1;
            sck_q <= s2[4];
        end
    end

    assign cs_s = s2[5];
    assign io_s = s2[3:0];
    assign rise = !cs_s && s2[4] && !sck_q;
    assign fall = !cs_s && !s2[4] && sck_q;
    assign operation_in_progress_flag = operation_in_progress_flag_o;
    assign cache_read_busy_flag = cache_read_busy_flag_o;
    assign idle = !operation_in_progress_flag && !cache_read_busy_flag;

    always_comb
    begin
        unique case (w_in)
            snd_pkg::W4: next_sh = {sh[19:0], io_s};
            snd_pkg::W2: next_sh = {sh[21:0], io_s[1:0]};
            default: next_sh = {sh[22:0], io_s[0]};
        endcase
    end

    assign next_cnt = cnt + {2'h0, w_in};
    assign opb = next_sh[7:0];
    assign op_done = rise && ph == snd_pkg::PH_OPC && next_cnt == snd_pkg::LEN_BYTE;
    assign adr_done = rise && ph == snd_pkg::PH_ADR && next_cnt == len;
    assign dmy_done = rise && ph == snd_pkg::PH_DMY && next_cnt == len;
    assign do_reset = op_done && opb == snd_pkg::OP_RESET;
    assign do_wren = op_done && opb == snd_pkg::OP_WREN && !operation_in_progress_flag;
    assign do_wrdi = op_done && opb == snd_pkg::OP_WRDI && !operation_in_progress_flag;
    assign do_last = op_done && opb == snd_pkg::OP_LAST && idle;
    assign do_page = adr_done && opc == snd_pkg::OP_PREAD && idle;
    assign do_rand = adr_done && opc == snd_pkg::OP_RAND && idle;

    // next phase and line widths per opcode
    always_comb
    begin
        d_ph = snd_pkg::PH_ADR;
        d_len = snd_pkg::LEN_COL;
        d_w = snd_pkg::W1;
        d_wo = snd_pkg::W1;
        d_src = snd_pkg::SRC_CACHE;
        unique case (opb)
            snd_pkg::OP_GETF:
            begin
                d_len = snd_pkg::LEN_BYTE;
                d_src = snd_pkg::SRC_FEAT;
            end
            snd_pkg::OP_PREAD, snd_pkg::OP_RAND: d_len = snd_pkg::LEN_ROW;
            snd_pkg::OP_ID:
            begin
                d_ph = snd_pkg::PH_DMY;
                d_len = snd_pkg::LEN_BYTE;
                d_src = snd_pkg::SRC_ID;
            end
            snd_pkg::OP_RD1A, snd_pkg::OP_RD1B: d_wo = snd_pkg::W1;
            snd_pkg::OP_RD2: d_wo = snd_pkg::W2;
            snd_pkg::OP_RD4: d_wo = snd_pkg::W4;
            snd_pkg::OP_RDD:
            begin
                d_w = snd_pkg::W2;
                d_wo = snd_pkg::W2;
            end
            snd_pkg::OP_RDQ:
            begin
                d_w = snd_pkg::W4;
                d_wo = snd_pkg::W4;
            end
            default: d_ph = snd_pkg::PH_IGN;
        endcase
        // while busy only status polls get a next phase; the reset opcode still acts through do_reset
        if (operation_in_progress_flag && opb != snd_pkg::OP_GETF)
        begin
            d_ph = snd_pkg::PH_IGN;
        end
    end

    // command and address shifter
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ph <= snd_pkg::PH_OPC;
            opc <= 8'h00;
            sh <= 24'h000000;
            cnt <= 5'h00;
            len <= 5'h00;
            w_in <= snd_pkg::W1;
            w_out <= snd_pkg::W1;
            src <= snd_pkg::SRC_CACHE;
            feat <= 8'h00;
        end
        else if (cs_s)
        begin
            ph <= snd_pkg::PH_OPC;
            cnt <= 5'h00;
            w_in <= snd_pkg::W1;
        end
        else if (rise)
        begin
            sh <= next_sh;
            cnt <= next_cnt;
            unique case (ph)
                snd_pkg::PH_OPC:
                    if (op_done)
                    begin
                        opc <= opb;
                        ph <= d_ph;
                        len <= d_len;
                        w_in <= d_w;
                        w_out <= d_wo;
                        src <= d_src;
                        cnt <= 5'h00;
                    end
                snd_pkg::PH_ADR:
                    if (adr_done)
                    begin
                        cnt <= 5'h00;
                        feat <= next_sh[7:0];
                        len <= (w_in == snd_pkg::W4) ? snd_pkg::LEN_QDMY : snd_pkg::LEN_BYTE;
                        if (opc == snd_pkg::OP_GETF)
                            ph <= snd_pkg::PH_DAT;
                        else if (len == snd_pkg::LEN_ROW)
                            ph <= snd_pkg::PH_IGN;
                        else
                            ph <= snd_pkg::PH_DMY;
                    end
                snd_pkg::PH_DMY:
                    if (dmy_done)
                        ph <= snd_pkg::PH_DAT;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        stat = 8'h00;
        stat[snd_pkg::ST_OIP] = operation_in_progress_flag;
        stat[snd_pkg::ST_WEL] = write_enable_latch_o;
        stat[snd_pkg::ST_ECC +: 2] = ecc_stat_o;
        stat[snd_pkg::ST_CACHE_READ_BUSY_FLAG] = cache_read_busy_flag;
        unique case (src)
            snd_pkg::SRC_ID: src_byte = idx ? DEV_ID : MFR_ID;
            snd_pkg::SRC_FEAT:
                if (feat == snd_pkg::FA_STAT)
                    src_byte = stat;
                else if (feat == snd_pkg::FA_CFG)
                    src_byte = {5'h00, cfg_sel_o};
                else if (feat == snd_pkg::FA_LOCK)
                    src_byte = lock_o;
                else
                    src_byte = 8'h00;
            default: src_byte = cache_data_i;
        endcase
        top = (bcnt == 3'h0) ? src_byte : sr;
        unique case (w_out)
            snd_pkg::W4:
            begin
                dv = top[7:4];
                oe_map = 4'hF;
            end
            snd_pkg::W2:
            begin
                dv = {2'h0, top[7:6]};
                oe_map = 4'h3;
            end
            default:
            begin
                dv = {2'h0, top[7], 1'b0};
                oe_map = 4'h2;
            end
        endcase
    end

    // data out, MSB first, one group per falling edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
            sr <= 8'h00;
            bcnt <= 3'h0;
            idx <= 1'b0;
            cache_col_o <= 12'h000;
        end
        else if (cs_s)
        begin
            io_oe_o <= 4'h0;
            bcnt <= 3'h0;
            idx <= 1'b0;
        end
        else
        begin
            if (adr_done && len == snd_pkg::LEN_COL)
                cache_col_o <= next_sh[11:0];
            if (fall && ph == snd_pkg::PH_DAT)
            begin
                io_o <= dv;
                io_oe_o <= oe_map;
                sr <= top << w_out;
                bcnt <= bcnt + w_out;
                // bump the column at byte start so the next byte is ready early
                if (bcnt == 3'h0)
                begin
                    idx <= !idx;
                    if (src == snd_pkg::SRC_CACHE)
                        cache_col_o <= cache_col_o + 12'h001;
                end
            end
        end
    end

    assign rc = ecc_en_i ? RC_C + ECC_C : RC_C;

    // busy timers; a reset opcode overrides anything running
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            operation_in_progress_flag_o <= 1'b0;
            cache_read_busy_flag_o <= 1'b0;
            otmr <= 12'h000;
            ctmr <= 12'h000;
            pend <= 1'b0;
            rrow <= 17'h00000;
            ecc_stat_o <= 2'h0;
        end
        else if (do_reset)
        begin
            operation_in_progress_flag_o <= 1'b1;
            otmr <= RST_C;
            cache_read_busy_flag_o <= 1'b0;
            ctmr <= 12'h000;
            pend <= 1'b0;
        end
        else if (do_page)
        begin
            operation_in_progress_flag_o <= 1'b1;
            otmr <= RD_C;
        end
        else if (do_rand)
        begin
            operation_in_progress_flag_o <= 1'b1;
            otmr <= rc;
            cache_read_busy_flag_o <= 1'b1;
            ctmr <= rc + RD_C;
            pend <= 1'b1;
            rrow <= next_sh[16:0];
        end
        else if (do_last)
        begin
            operation_in_progress_flag_o <= 1'b1;
            otmr <= rc;
        end
        else
        begin
            if (operation_in_progress_flag)
            begin
                otmr <= otmr - 12'h001;
                if (otmr == 12'h001)
                begin
                    operation_in_progress_flag_o <= 1'b0;
                    pend <= 1'b0;
                    ecc_stat_o <= ecc_stat_i;
                end
            end
            if (cache_read_busy_flag)
            begin
                ctmr <= ctmr - 12'h001;
                if (ctmr == 12'h001)
                    cache_read_busy_flag_o <= 1'b0;
            end
        end
    end

    always_comb
    begin
        next_req = arr_o;
        next_req.valid = 1'b0;
        if (do_reset)
            next_req = '{1'b1, snd_pkg::AR_LOAD_CACHE, 17'h00000};
        else if (do_page)
            next_req = '{1'b1, snd_pkg::AR_LOAD_CACHE, next_sh[16:0]};
        else if (do_rand || do_last)
            next_req = '{1'b1, snd_pkg::AR_TO_CACHE, next_sh[16:0]};
        else if (pend && operation_in_progress_flag && otmr == 12'h001)
            next_req = '{1'b1, snd_pkg::AR_LOAD_DATA, rrow};
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            arr_o <= '0;
            plane_o <= 1'b0;
        end
        else
        begin
            arr_o <= next_req;
            plane_o <= next_req.row[snd_pkg::PLANE_BIT];
        end
    end

    // latch and configuration; the reset opcode wins over a port write
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            write_enable_latch_o <= 1'b0;
            cfg_sel_o <= 3'h0;
        end
        else
        begin
            if (do_reset || do_wrdi)
                write_enable_latch_o <= 1'b0;
            else if (do_wren)
                write_enable_latch_o <= 1'b1;
            if (do_reset)
                cfg_sel_o <= 3'h0;
            else if (cfg_wr_i)
                cfg_sel_o <= cfg_i;
        end
    end

    // lock bits ignore the reset opcode
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            lock_o <= 8'h00;
        else if (lock_wr_i)
            lock_o <= lock_i;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_abort;
        do_reset;
    endsequence
    sequence s_clean;
        operation_in_progress_flag && !cache_read_busy_flag && !write_enable_latch_o && cfg_sel_o == 3'h0;
    endsequence
    property p_reset_abort;
        s_abort |=> s_clean;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset not clean");
    property p_reset_load;
        s_abort |=> arr_o.valid && arr_o.op == snd_pkg::AR_LOAD_CACHE && arr_o.row == 17'h0;
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("no page zero load");
    property p_poll;
        op_done && operation_in_progress_flag && opb == snd_pkg::OP_GETF |=> ph == snd_pkg::PH_ADR;
    endproperty
    a_poll: assert property (p_poll) else $error("poll refused while busy");
    property p_lock;
        !lock_wr_i |=> $stable(lock_o);
    endproperty
    a_lock: assert property (p_lock) else $error("lock changed");
    property p_wel;
        do_wren |=> write_enable_latch_o;
    endproperty
    a_wel: assert property (p_wel) else $error("latch not set");
    property p_wrdi;
        do_wrdi |=> !write_enable_latch_o;
    endproperty
    a_wrdi: assert property (p_wrdi) else $error("latch not cleared");
    property p_rand;
        do_rand |=> operation_in_progress_flag && cache_read_busy_flag && arr_o.op == snd_pkg::AR_TO_CACHE;
    endproperty
    a_rand: assert property (p_rand) else $error("random read not started");
    property p_last;
        disable iff (rst_i || do_reset)
        do_last && !ecc_en_i |-> ##RCN operation_in_progress_flag && !cache_read_busy_flag ##1 !operation_in_progress_flag;
    endproperty
    a_last: assert property (p_last) else $error("last read timing");
    property p_release;
        cs_s |=> io_oe_o == 4'h0;
    endproperty
    a_release: assert property (p_release) else $error("lines driven while deselected");
    // plane follows the commanded row, not just the registered copy
    property p_plane;
        do_page || do_rand |=> plane_o == $past(next_sh[snd_pkg::PLANE_BIT]);
    endproperty
    a_plane: assert property (p_plane) else $error("plane mismatch");
endmodule : snd_seq

// ==== tb/snd_host.sv ====
/* snd_host: SPI host model in clock mode 0, with one transfer task.
   Assumes the bench resolves the shared data pins from both enables. */
module snd_host (
    // serial pins
    output logic            cs_n_o,
    output logic            sck_o,
    output logic [3:0]      io_o,
    output logic [3:0]      io_oe_o,
    input  wire logic [3:0] io_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cs_n_o  = 1'b1;
        sck_o   = 1'b0;
        io_o    = 4'h0;
        io_oe_o = 4'h0;
    end

    // drive, rise (both sides sample), fall
    task automatic tick(input logic [3:0] v, input logic [3:0] oe, input int w,
                        inout logic [15:0] rd);
        io_o    = v;
        io_oe_o = oe;
        #32 sck_o = 1'b1;
        rd = (rd << w) | 16'(w == 1 ? {3'h0, io_i[1]} : io_i & 4'(15 >> (4 - w)));
        #32 sck_o = 1'b0;
    endtask : tick

    // opcode on io0, na address bits aw per clock, nd dummy clocks, nr bits read
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int na,
                        input int aw, input int nd, input int dw, input int nr,
                        output logic [15:0] rd);
        logic [23:0] sh;
        logic [15:0] x;
        sh = a << (24 - na);
        rd = 16'h0;
        x  = 16'h0;
        cs_n_o = 1'b0;
        #32;
        for (int i = 7; i >= 0; i--)
            tick({3'h0, op[i]}, 4'h1, 1, x);
        for (int i = 0; i < na / aw; i++)
        begin
            tick(4'(sh[23:20] >> (4 - aw)), 4'(15 >> (4 - aw)), aw, x);
            sh = sh << aw;
        end
        // released during dummy and data: the device owns the lines
        for (int i = 0; i < nd; i++)
            tick(4'h0, 4'h0, 1, x);
        for (int i = 0; i < nr / dw; i++)
            tick(4'h0, 4'h0, dw, rd);
        #32 cs_n_o = 1'b1;
        #96;
    endtask : xfer
endmodule : snd_host

// ==== tb/snd_seq_tb.sv ====
/* snd_seq_tb: command sequences on the serial pins with expected values.
   Assumes a combinational cache pattern and the host model in snd_host. */
module snd_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MFR = 8'hC3; // arbitrary value
    localparam logic [7:0] DEV = 8'h3C; // arbitrary value
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  ecc_en = 1'b0;
    logic                  cfg_wr = 1'b0;
    logic                  lock_wr = 1'b0;
    logic                  junk = 1'b0;
    logic [2:0]            cfg = 3'h0, cfg_o;
    logic [7:0]            lock = 8'h0, lock_o, st;
    logic [1:0]            ecc_o;
    logic                  cs_n, sck, plane, write_enable_latch, operation_in_progress_flag, crb;
    logic [3:0]            h_io, h_oe, d_io, d_oe;
    wire  [3:0]            pin;
    logic [11:0]           col, c;
    logic [15:0]           rd;
    snd_pkg::snd_arr_req_t arr, last;
    int                    err_count = 0, n_checks = 0, oip_cnt = 0, oip_last = 0;
    logic [7:0]            OPS [6] = '{snd_pkg::OP_RD1A, snd_pkg::OP_RD1B, snd_pkg::OP_RD2,
                                       snd_pkg::OP_RD4, snd_pkg::OP_RDD, snd_pkg::OP_RDQ};
    int                    AW [6] = '{1, 1, 1, 1, 2, 4};
    int                    ND [6] = '{8, 8, 8, 8, 4, 4};
    int                    DW [6] = '{1, 1, 2, 4, 2, 4};

    always #2 clk = ~clk;
    // released lines show a changing pattern, never the last value
    always @(posedge clk) junk <= ~junk;
    assign pin = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {4{junk}});

    always @(posedge clk)
    begin
        if (arr.valid)
            last <= arr;
        if (operation_in_progress_flag)
            oip_cnt <= oip_cnt + 1;
        else if (oip_cnt != 0)
        begin
            oip_last <= oip_cnt;
            oip_cnt  <= 0;
        end
    end

    snd_host snd_host_i (.cs_n_o(cs_n), .sck_o(sck), .io_o(h_io), .io_oe_o(h_oe), .io_i(pin));

    snd_seq #(.MFR_ID(MFR), .DEV_ID(DEV)) snd_seq_i (
        .clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck), .io_i(pin), .io_o(d_io),
        .io_oe_o(d_oe), .cache_col_o(col), .cache_data_i(col[7:0] ^ 8'h5C), .arr_o(arr),
        .plane_o(plane), .ecc_stat_i(2'h2), .ecc_en_i(ecc_en), .cfg_wr_i(cfg_wr),
        .cfg_i(cfg), .lock_wr_i(lock_wr), .lock_i(lock), .write_enable_latch_o(write_enable_latch),
        .operation_in_progress_flag_o(operation_in_progress_flag), .cache_read_busy_flag_o(crb),
        .ecc_stat_o(ecc_o), .cfg_sel_o(cfg_o), .lock_o(lock_o));

    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("BAD %s exp %0h got %0h", nm, e, g);
            err_count++;
        end
    endtask : chk

    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na, input int aw,
                       input int nd, input int dw, input int nr);
        @(posedge clk);
        #1 snd_host_i.xfer(op, a, na, aw, nd, dw, nr, rd);
    endtask : cmd

    task automatic stat;
        cmd(snd_pkg::OP_GETF, 24'(snd_pkg::FA_STAT), 8, 1, 0, 1, 8);
        st = rd[7:0];
    endtask : stat

    // bounded wait for the flag, and for cache busy too when both is set
    task automatic till(input logic both);
        int n;
        for (n = 0; n < 3000 && (operation_in_progress_flag | (both & crb)) !== 1'b0; n++)
            @(posedge clk);
        // let the busy-length recorder settle before anyone reads it
        #1;
        if (n == 3000)
        begin
            $display("BAD wait exp idle got busy");
            err_count++;
            summarize();
        end
    endtask : till

    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        chk("reset outs", 24'h0, 24'({write_enable_latch, operation_in_progress_flag, crb, cfg_o, lock_o, d_oe}));
        cmd(snd_pkg::OP_ID, 24'h0, 0, 1, 8, 1, 16);
        chk("id", {8'h0, MFR, DEV}, 24'(rd));
        cmd(snd_pkg::OP_WREN, 24'h0, 0, 1, 0, 1, 0);
        stat();
        chk("wel set", 24'h1, 24'({write_enable_latch, st[snd_pkg::ST_WEL]}) >> 1);
        chk("wel st", 24'h1, 24'(st[snd_pkg::ST_WEL]));
        cmd(snd_pkg::OP_WRDI, 24'h0, 0, 1, 0, 1, 0);
        chk("wel clr", 24'h0, 24'(write_enable_latch));
        cmd(snd_pkg::OP_PREAD, 24'h01A3C5, 24, 1, 0, 1, 0);
        cmd(snd_pkg::OP_RAND, 24'h000040, 24, 1, 0, 1, 0);
        chk("busy refuse", {4'h0, 1'b1, snd_pkg::AR_LOAD_CACHE, 17'h1A3C5}, 24'(last));
        chk("plane", 24'h1, 24'(plane));
        stat();
        chk("poll busy", 24'h1, 24'(st[snd_pkg::ST_OIP]));
        till(1'b1);
        chk("read time", 24'(snd_pkg::cyc(snd_pkg::T_RD_NS)), 24'(oip_last));
        for (int i = 0; i < 6; i++)
        begin
            c = 12'h87E - 12'(i);
            cmd(OPS[i], 24'(c), 16, AW[i], ND[i], DW[i], 16);
            chk("cache rd", {8'h0, c[7:0] ^ 8'h5C, (c[7:0] + 8'h1) ^ 8'h5C}, 24'(rd));
            chk("released", 24'h0, 24'(d_oe));
        end
        for (int e = 0; e < 2; e++)
        begin
            ecc_en = 1'(e);
            cmd(snd_pkg::OP_RAND, 24'h000040, 24, 1, 0, 1, 0);
            chk("rand busy", {22'h0, 2'b11}, 24'({operation_in_progress_flag, crb}));
            chk("to cache", 24'(snd_pkg::AR_TO_CACHE), 24'(last.op));
            till(1'b0);
            chk("crb holds", 24'h1, 24'(crb));
            chk("load data", {4'h0, 1'b1, snd_pkg::AR_LOAD_DATA, 17'h40}, 24'(last));
            chk("copy time", 24'((e + 1) * snd_pkg::cyc(snd_pkg::T_RCBSY_NS)), 24'(oip_last));
            till(1'b1);
        end
        chk("ecc stat", 24'h2, 24'(ecc_o));
        ecc_en = 1'b0;
        cmd(snd_pkg::OP_LAST, 24'h0, 0, 1, 0, 1, 0);
        chk("last busy", {22'h0, 2'b10}, 24'({operation_in_progress_flag, crb}));
        chk("last op", 24'(snd_pkg::AR_TO_CACHE), 24'(last.op));
        till(1'b1);
        chk("last time", 24'(snd_pkg::cyc(snd_pkg::T_RCBSY_NS)), 24'(oip_last));
        @(posedge clk);
        #1 {cfg_wr, cfg, lock_wr, lock} = {1'b1, 3'h5, 1'b1, 8'h3C};
        @(posedge clk);
        #1 {cfg_wr, lock_wr} = 2'b00;
        cmd(snd_pkg::OP_WREN, 24'h0, 0, 1, 0, 1, 0);
        cmd(snd_pkg::OP_PREAD, 24'h00ABCD, 24, 1, 0, 1, 0);
        cmd(snd_pkg::OP_RESET, 24'h0, 0, 1, 0, 1, 0);
        chk("page zero", {4'h0, 1'b1, snd_pkg::AR_LOAD_CACHE, 17'h0}, 24'(last));
        chk("rst state", {13'h0, 3'h0, 8'h3C}, 24'({write_enable_latch, cfg_o, lock_o}));
        stat();
        chk("rst poll", 24'h1, 24'(st[snd_pkg::ST_OIP]));
        till(1'b1);
        chk("aborted", 24'h1, 24'(oip_last < snd_pkg::cyc(snd_pkg::T_RD_NS)));
        summarize();
    end
endmodule : snd_seq_tb
